// ==== sssfl_status.sv ====
// Second switch status register, low 22 bits: sticky and mirrored status flags.
// Assumes event inputs are single-cycle pulses from logic on clk and the register
// port comes from the SPI decoder on the same clock.
`timescale 1ns/1ns
`default_nettype none

module sssfl_status
    import sssfl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    // Register port from the SPI decoder.
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Configuration.
    input wire logic generic_spi,
    input wire logic cut_through,
    input wire logic low_priority_first,
    input wire logic tx_ready_on_empty,
    input wire logic [GAP_W-1:0] port1_gap_threshold,
    // Events and levels from the switch core.
    input wire logic capture_a_event,
    input wire logic capture_b_event,
    input wire logic phy2_irq,
    input wire logic tx_size_ecc_error,
    input wire logic rx_size_ecc_error,
    input wire logic spi_crc_error,
    input wire logic tx_done,
    input wire logic tx_fifo_empty,
    input wire logic port1_hi_present,
    input wire logic port1_lo_present,
    input wire logic port1_cut_ready,
    input wire logic port2_hi_present,
    input wire logic port2_lo_present,
    input wire logic port2_cut_ready,
    // Port 1 receive pins, asynchronous.
    input wire logic port1_rx_clk,
    input wire logic port1_rx_dv,
    // Actions toward the FIFOs and the host port.
    output logic tx_fifo_flush,
    output logic rx_fifo_flush,
    output logic port1_frame_drop,
    output logic port1_read_high,
    output logic port2_read_high,
    output logic host_port2_next,
    output logic host_port_decided
);

    // --------------------------------------------------------------------
    // State
    // --------------------------------------------------------------------
    typedef struct packed {
        logic cap_b;
        logic cap_a;
        logic phy_irq;
        logic p2_urgent;
        logic p2_waiting;
        logic tx_ecc;
        logic rx_ecc;
        logic spi_crc;
        logic gap_fault;
        logic p1_urgent;
        logic p1_waiting;
        logic tx_ready;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic tx_flush;
        logic rx_flush;
        logic p1_high;
        logic p2_high;
        logic p2_next;
        logic decided;
    } sssfl_status_s;

    sssfl_status_s s_q;
    sssfl_status_s s_d;
    logic gap_fault_pulse;
    logic hit_wr;
    logic tx_ready_set;

    // Apply a write-one-to-clear with the set taking precedence.
    function automatic logic sticky(input logic cur, input logic set, input logic clr);
        sticky = set | (cur & ~clr);
    endfunction : sticky

    // Choose the high priority queue unless both queues hold frames and low goes first.
    function automatic logic pick_high(input logic hi, input logic lo, input logic lpf);
        pick_high = hi & ~(lo & lpf);
    endfunction : pick_high

    // Pack the flags into their register positions; every other bit reads zero.
    function automatic logic [DATA_W-1:0] pack_flags(input sssfl_status_s s);
        pack_flags = STATUS_SECOND_RESET;
        pack_flags[BIT_CAPTURE_B] = s.cap_b;
        pack_flags[BIT_CAPTURE_A] = s.cap_a;
        pack_flags[BIT_PHY_IRQ] = s.phy_irq;
        pack_flags[BIT_P2_URGENT] = s.p2_urgent;
        pack_flags[BIT_P2_WAITING] = s.p2_waiting;
        pack_flags[BIT_TX_ECC] = s.tx_ecc;
        pack_flags[BIT_RX_ECC] = s.rx_ecc;
        pack_flags[BIT_SPI_CRC] = s.spi_crc;
        pack_flags[BIT_P1_GAP_FAULT] = s.gap_fault;
        pack_flags[BIT_P1_URGENT] = s.p1_urgent;
        pack_flags[BIT_P1_WAITING] = s.p1_waiting;
        pack_flags[BIT_TX_READY] = s.tx_ready;
    endfunction : pack_flags

    // --------------------------------------------------------------------
    // Port 1 gap checker
    // --------------------------------------------------------------------
    sssfl_gap_check u_gap (
        .clk(clk),
        .reset(reset),
        .rx_clk_pin(port1_rx_clk),
        .rx_dv_pin(port1_rx_dv),
        .port1_gap_threshold(port1_gap_threshold),
        .gap_fault_pulse(gap_fault_pulse),
        .frame_drop(port1_frame_drop)
    );

    // Register address decode and the transmit-ready set condition.
    assign hit_wr = reg_wr && (reg_addr == STATUS_SECOND_ADDR);
    assign tx_ready_set = generic_spi & tx_done & (~tx_ready_on_empty | tx_fifo_empty);

    // --------------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------------
    // Sticky flags, mirrors and the register read path. Mirrors lag their source by one
    // cycle, which keeps the read data a clean flop output at the cost of that latency.
    always_comb begin
        s_d = s_q;
        s_d.cap_b = sticky(s_q.cap_b, capture_b_event, hit_wr & reg_wdata[BIT_CAPTURE_B]);
        s_d.cap_a = sticky(s_q.cap_a, capture_a_event, hit_wr & reg_wdata[BIT_CAPTURE_A]);
        s_d.phy_irq = phy2_irq;
        s_d.p2_urgent = generic_spi & port2_hi_present;
        s_d.p1_urgent = generic_spi & port1_hi_present;
        if (cut_through) begin
            s_d.p2_waiting = generic_spi & port2_cut_ready;
            s_d.p1_waiting = generic_spi & port1_cut_ready;
        end else begin
            s_d.p2_waiting = generic_spi & (port2_hi_present | port2_lo_present);
            s_d.p1_waiting = generic_spi & (port1_hi_present | port1_lo_present);
        end
        s_d.tx_ecc = sticky(s_q.tx_ecc, tx_size_ecc_error, hit_wr & reg_wdata[BIT_TX_ECC]);
        s_d.rx_ecc = sticky(s_q.rx_ecc, rx_size_ecc_error, hit_wr & reg_wdata[BIT_RX_ECC]);
        s_d.spi_crc = sticky(s_q.spi_crc, generic_spi & spi_crc_error,
                             hit_wr & reg_wdata[BIT_SPI_CRC]);
        s_d.gap_fault = sticky(s_q.gap_fault, gap_fault_pulse,
                               hit_wr & reg_wdata[BIT_P1_GAP_FAULT]);
        s_d.tx_ready = sticky(s_q.tx_ready, tx_ready_set, hit_wr & reg_wdata[BIT_TX_READY]);
        s_d.tx_flush = tx_size_ecc_error;
        s_d.rx_flush = rx_size_ecc_error;
        s_d.p1_high = pick_high(port1_hi_present, port1_lo_present, low_priority_first);
        s_d.p2_high = pick_high(port2_hi_present, port2_lo_present, low_priority_first);
        s_d.decided = s_q.p1_urgent ^ s_q.p2_urgent;
        s_d.p2_next = s_q.p2_urgent & ~s_q.p1_urgent;
        s_d.rvalid = reg_rd;
        if (reg_rd) begin
            // An unmapped address answers zero rather than stale data.
            s_d.rdata = (reg_addr == STATUS_SECOND_ADDR) ? pack_flags(s_q) : STATUS_SECOND_RESET;
        end
    end

    // --------------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------------
    // Every field clears to zero so the register reads its reset value.
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign reg_rvalid = s_q.rvalid;
    assign tx_fifo_flush = s_q.tx_flush;
    assign rx_fifo_flush = s_q.rx_flush;
    assign port1_read_high = s_q.p1_high;
    assign port2_read_high = s_q.p2_high;
    assign host_port2_next = s_q.p2_next;
    assign host_port_decided = s_q.decided;

    // --------------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------------
    sequence s_clear_write(int b);
        hit_wr && reg_wdata[b];
    endsequence

    sequence s_idle_write(int b);
        !hit_wr || !reg_wdata[b];
    endsequence

    property p_capture_set;
        @(posedge clk) disable iff (reset)
        capture_a_event |=> s_q.cap_a;
    endproperty
    a_capture_set: assert property (p_capture_set) else $error("capture A flag not set");

    property p_capture_clear;
        @(posedge clk) disable iff (reset)
        s_clear_write(BIT_CAPTURE_B) ##0 !capture_b_event |=> !s_q.cap_b;
    endproperty
    a_capture_clear: assert property (p_capture_clear) else $error("capture B flag not cleared");

    property p_phy_mirror;
        @(posedge clk) disable iff (reset)
        ##1 s_q.phy_irq == $past(phy2_irq);
    endproperty
    a_phy_mirror: assert property (p_phy_mirror) else $error("PHY flag does not follow input");

    property p_tx_ecc_flush;
        @(posedge clk) disable iff (reset)
        tx_size_ecc_error |=> tx_fifo_flush && s_q.tx_ecc;
    endproperty
    a_tx_ecc_flush: assert property (p_tx_ecc_flush) else $error("Tx ECC error missed");

    property p_rx_ecc_flush;
        @(posedge clk) disable iff (reset)
        rx_size_ecc_error |=> rx_fifo_flush && s_q.rx_ecc;
    endproperty
    a_rx_ecc_flush: assert property (p_rx_ecc_flush) else $error("Rx ECC error missed");

    property p_crc_generic_only;
        @(posedge clk) disable iff (reset)
        spi_crc_error && !generic_spi && !s_q.spi_crc |=> !s_q.spi_crc;
    endproperty
    a_crc_generic_only: assert property (p_crc_generic_only) else $error("CRC flag set outside generic SPI");

    property p_tx_ready_wait_empty;
        @(posedge clk) disable iff (reset)
        tx_done && tx_ready_on_empty && !tx_fifo_empty && !s_q.tx_ready |=> !s_q.tx_ready;
    endproperty
    a_tx_ready_wait_empty: assert property (p_tx_ready_wait_empty) else $error("Tx ready set with FIFO busy");

    property p_tx_ready_holds;
        @(posedge clk) disable iff (reset)
        s_q.tx_ready ##0 s_idle_write(BIT_TX_READY) |=> s_q.tx_ready;
    endproperty
    a_tx_ready_holds: assert property (p_tx_ready_holds) else $error("Tx ready lost without a clear");

    property p_set_beats_clear;
        @(posedge clk) disable iff (reset)
        s_clear_write(BIT_TX_ECC) ##0 tx_size_ecc_error |=> s_q.tx_ecc;
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat a new event");

    property p_low_first;
        @(posedge clk) disable iff (reset)
        port1_hi_present && port1_lo_present && low_priority_first |=> !port1_read_high;
    endproperty
    a_low_first: assert property (p_low_first) else $error("priority order not inverted");

    property p_lone_urgent;
        @(posedge clk) disable iff (reset)
        s_q.p2_urgent && !s_q.p1_urgent |=> host_port_decided && host_port2_next;
    endproperty
    a_lone_urgent: assert property (p_lone_urgent) else $error("lone urgent port not chosen");

    property p_reset_zero;
        @(posedge clk)
        reset |=> pack_flags(s_q) == STATUS_SECOND_RESET && !reg_rvalid;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset");

endmodule : sssfl_status

`default_nettype wire

// ==== sssfl_pkg.sv ====
// Constants shared by the second switch status register and its gap checker.
// Assumes the register sits at one address of the device's internal register port.
`default_nettype none

package sssfl_pkg;

    // --------------------------------------------------------------------
    // Register placement and width
    // --------------------------------------------------------------------
    localparam int REG_ADDR_W = 8;
    localparam logic [REG_ADDR_W-1:0] STATUS_SECOND_ADDR = 8'h09;
    localparam int DATA_W = 32;
    localparam logic [DATA_W-1:0] STATUS_SECOND_RESET = 32'h0000_0000;

    // --------------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------------
    localparam int BIT_CAPTURE_B = 21;
    localparam int BIT_CAPTURE_A = 20;
    localparam int BIT_PHY_IRQ = 19;
    localparam int BIT_P2_URGENT = 18;
    localparam int BIT_P2_WAITING = 17;
    localparam int BIT_TX_ECC = 12;
    localparam int BIT_RX_ECC = 11;
    localparam int BIT_SPI_CRC = 10;
    localparam int BIT_P1_GAP_FAULT = 8;
    localparam int BIT_P1_URGENT = 5;
    localparam int BIT_P1_WAITING = 4;
    localparam int BIT_TX_READY = 3;

    // --------------------------------------------------------------------
    // Gap checker sizing
    // --------------------------------------------------------------------
    localparam int GAP_W = 8;
    localparam logic [GAP_W-1:0] GAP_COUNT_RESET = 8'hff;
    localparam int SYNC_STAGES = 2;

    // One-hot states of the port 1 gap checker.
    typedef enum logic [2:0] {
        SSSFL_GAP = 3'h1,
        SSSFL_RECV = 3'h2,
        SSSFL_DROP = 3'h4
    } sssfl_gap_state_e;

endpackage : sssfl_pkg

`default_nettype wire

// ==== sssfl_gap_check.sv ====
// Port 1 interframe gap checker: measures idle link clock edges between frames.
// Assumes the receive clock and data valid are pins from the PHY, asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none

module sssfl_gap_check
    import sssfl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic rx_clk_pin,
    input wire logic rx_dv_pin,
    input wire logic [GAP_W-1:0] port1_gap_threshold,
    output logic gap_fault_pulse,
    output logic frame_drop
);

    // --------------------------------------------------------------------
    // State
    // --------------------------------------------------------------------
    typedef struct packed {
        logic [SYNC_STAGES-1:0] clk_sync;
        logic [SYNC_STAGES-1:0] dv_sync;
        logic clk_prev;
        sssfl_gap_state_e state;
        logic [GAP_W-1:0] gap_cnt;
        logic fault;
    } sssfl_gap_s;

    sssfl_gap_s s_q;
    sssfl_gap_s s_d;
    logic link_edge;
    logic dv_now;

    // Only the second synchroniser stage is looked at by any logic.
    assign link_edge = s_q.clk_sync[1] & ~s_q.clk_prev;
    assign dv_now = s_q.dv_sync[1];

    // Next state: count idle link edges, judge the gap at the start of each frame.
    always_comb begin
        s_d = s_q;
        s_d.clk_sync = {s_q.clk_sync[0], rx_clk_pin};
        s_d.dv_sync = {s_q.dv_sync[0], rx_dv_pin};
        s_d.clk_prev = s_q.clk_sync[1];
        s_d.fault = 1'b0;
        if (link_edge) begin
            case (s_q.state)
                SSSFL_GAP: begin
                    if (dv_now) begin
                        if (s_q.gap_cnt < port1_gap_threshold) begin
                            s_d.state = SSSFL_DROP;
                            s_d.fault = 1'b1;
                        end else begin
                            s_d.state = SSSFL_RECV;
                        end
                    end else if (s_q.gap_cnt != GAP_COUNT_RESET) begin
                        s_d.gap_cnt = s_q.gap_cnt + 8'h01; // Saturates so long idles stay legal.
                    end
                end
                SSSFL_RECV, SSSFL_DROP: begin
                    if (!dv_now) begin
                        s_d.state = SSSFL_GAP;
                        s_d.gap_cnt = 8'h01;
                    end
                end
                default: begin
                    s_d.state = SSSFL_GAP;
                end
            endcase
        end
    end

    // Register the state; the gap count starts saturated so the first frame passes.
    // The link clock sampler starts high, so a pin already high after reset gives no false rising edge.
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '{clk_sync: '1, dv_sync: '0, clk_prev: 1'b1, state: SSSFL_GAP,
                     gap_cnt: GAP_COUNT_RESET, fault: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign gap_fault_pulse = s_q.fault;
    assign frame_drop = (s_q.state == SSSFL_DROP);

    // --------------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------------
    property p_fault_drops;
        @(posedge clk) disable iff (reset)
        s_q.fault |-> s_q.state == SSSFL_DROP ##1 !s_q.fault;
    endproperty
    a_fault_drops: assert property (p_fault_drops) else $error("gap fault without drop state");

endmodule : sssfl_gap_check

`default_nettype wire

// ==== sssfl_host_model.sv ====
// Host model of the SPI side: single-word register reads and write-one-to-clear writes.
// Assumes it shares clk with the status block and drives its register strobe port.
`timescale 1ns/1ns
`default_nettype none

module sssfl_host_model
    import sssfl_pkg::*;
(
    input wire logic clk,
    output logic [REG_ADDR_W-1:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    // Idle port at time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0000_0000;
    end

    // Released lines show the inverse of their last value, so stale data never passes.
    task automatic rd(input logic [REG_ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic ok);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask : rd

    // One write strobe per call.
    task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // The cause behind bit 19 sits in the PHY's own status, fetched over management, left out here.
    // A lone urgent port is read next; with both or neither the choice is open.
    function automatic logic next_port2(input logic [DATA_W-1:0] s);
        return s[BIT_P2_URGENT] & ~s[BIT_P1_URGENT];
    endfunction : next_port2
endmodule : sssfl_host_model

`default_nettype wire

// ==== sssfl_status_bench.sv ====
// Self-checking bench for the second switch status register and its gap checker.
// Assumes the host model owns the register port; the bench drives every other input.
`timescale 1ns/1ns
`default_nettype none

module sssfl_status_bench
    import sssfl_pkg::*;
;
    logic clk, reset, wr, rd, rvalid, gen, cut, lpf, roe, done, empty, irq, lclk, dv;
    logic txf, rxf, drop, r1h, r2h, p2n, dec, pf;
    logic [7:0] addr, thr;
    logic [31:0] wdata, rdata, seed, r, m, e;
    logic [4:0] ev;
    logic [5:0] lv;
    int n_errors, n_tests;
    int bits [5] = '{BIT_CAPTURE_B, BIT_CAPTURE_A, BIT_TX_ECC, BIT_RX_ECC, BIT_SPI_CRC};

    sssfl_host_model host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
        .reg_rdata(rdata), .reg_rvalid(rvalid));

    sssfl_status dut (.clk(clk), .reset(reset), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
        .reg_rdata(rdata), .reg_rvalid(rvalid), .generic_spi(gen), .cut_through(cut), .low_priority_first(lpf),
        .tx_ready_on_empty(roe), .port1_gap_threshold(thr), .capture_a_event(ev[1]), .capture_b_event(ev[0]),
        .phy2_irq(irq), .tx_size_ecc_error(ev[2]), .rx_size_ecc_error(ev[3]), .spi_crc_error(ev[4]),
        .tx_done(done), .tx_fifo_empty(empty), .port1_hi_present(lv[0]), .port1_lo_present(lv[1]),
        .port1_cut_ready(lv[2]), .port2_hi_present(lv[3]), .port2_lo_present(lv[4]), .port2_cut_ready(lv[5]),
        .port1_rx_clk(lclk), .port1_rx_dv(dv), .tx_fifo_flush(txf), .rx_fifo_flush(rxf),
        .port1_frame_drop(drop), .port1_read_high(r1h), .port2_read_high(r2h), .host_port2_next(p2n),
        .host_port_decided(dec));

    // The 50 MHz clock; the link clock runs free with an unrelated phase.
    always #10 clk = ~clk;
    initial begin
        lclk = 1'b0;
        #7;
        forever #80 lclk = ~lclk;
    end

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Mirrored levels as the host should see them; generic-only bits read 0 otherwise.
    function automatic logic [31:0] mirror();
        logic [31:0] v;
        v = 32'h0000_0000;
        v[BIT_PHY_IRQ] = irq;
        v[BIT_P2_URGENT] = gen & lv[3];
        v[BIT_P2_WAITING] = gen & (cut ? lv[5] : (lv[3] | lv[4]));
        v[BIT_P1_URGENT] = gen & lv[0];
        v[BIT_P1_WAITING] = gen & (cut ? lv[2] : (lv[0] | lv[1]));
        return v;
    endfunction : mirror

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] d;
        logic ok;
        host.rd(a, d, ok);
        chk("rvalid", {31'h0, ok}, 32'h0000_0001);
        chk("rdata", d, x);
    endtask : rdchk

    task automatic pulse(input int i);
        @(posedge clk);
        #1;
        ev[i] = 1'b1;
        @(posedge clk);
        #1;
        ev[i] = 1'b0;
    endtask : pulse

    // Idle for gap link edges while checking the last frame's flag, then send one frame.
    task automatic frame(input int gap, input logic fault);
        fork
            repeat (gap) @(negedge lclk);
            begin
                repeat (2) @(negedge lclk);
                rdchk(STATUS_SECOND_ADDR, pf ? 32'h0000_0100 : 32'h0000_0000);
                host.wr(STATUS_SECOND_ADDR, 32'h0000_0100);
            end
        join
        dv = 1'b1;
        repeat (3) @(negedge lclk);
        chk("drop", {31'h0, drop}, {31'h0, fault});
        repeat (3) @(negedge lclk);
        dv = 1'b0;
        pf = fault;
    endtask : frame

    task automatic results();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    // Watchdog, far beyond the thousand or so cycles the run needs.
    initial begin
        #500_000;
        n_errors++;
        results();
    end

    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial begin
        {clk, gen, cut, lpf, roe, done, empty, irq, dv, pf} = 10'h000;
        ev = 5'h00;
        lv = 6'h00;
        thr = 8'h06;
        seed = 32'h4eb1_7c07;
        n_errors = 0;
        n_tests = 0;
        reset = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        reset = 1'b0;
        rdchk(STATUS_SECOND_ADDR, STATUS_SECOND_RESET);
        rdchk(8'h0a, 32'h0000_0000);
        gen = 1'b1;
        for (int i = 0; i < 5; i++) begin
            e = 32'h0000_0001 << bits[i];
            pulse(i);
            chk("txflush", {31'h0, txf}, {31'h0, i == 2});
            chk("rxflush", {31'h0, rxf}, {31'h0, i == 3});
            rdchk(STATUS_SECOND_ADDR, e);
            host.wr(STATUS_SECOND_ADDR, ~e);
            rdchk(STATUS_SECOND_ADDR, e);
            host.wr(8'h08, 32'hffff_ffff);
            rdchk(STATUS_SECOND_ADDR, e);
            host.wr(STATUS_SECOND_ADDR, e);
            rdchk(STATUS_SECOND_ADDR, 32'h0000_0000);
        end
        // A clearing write on the same edge as a new capture and a new Tx ECC error must lose.
        fork
            pulse(1);
            pulse(2);
            host.wr(STATUS_SECOND_ADDR, 32'h0010_1000);
        join
        rdchk(STATUS_SECOND_ADDR, 32'h0010_1000);
        host.wr(STATUS_SECOND_ADDR, 32'h0010_1000);
        gen = 1'b0;
        pulse(4);
        rdchk(STATUS_SECOND_ADDR, 32'h0000_0000);
        // Transmit ready under both completion settings and both protocols.
        for (int k = 0; k < 12; k++) begin
            // The first pass waits on a busy FIFO under generic SPI, so the flag must stay clear.
            r = (k == 0) ? 32'h0000_0005 : xs();
            {gen, empty, roe} = r[2:0];
            e = (gen & (!roe | empty)) ? 32'h0000_0008 : 32'h0000_0000;
            @(posedge clk);
            #1;
            done = 1'b1;
            @(posedge clk);
            #1;
            done = 1'b0;
            rdchk(STATUS_SECOND_ADDR, e);
            host.wr(STATUS_SECOND_ADDR, 32'hffff_fff7);
            rdchk(STATUS_SECOND_ADDR, e);
            host.wr(STATUS_SECOND_ADDR, 32'h0000_0008);
            rdchk(STATUS_SECOND_ADDR, 32'h0000_0000);
        end
        // Mirrors and queue order; the first pass sets every level at once.
        for (int k = 0; k < 24; k++) begin
            r = (k == 0) ? 32'h0000_03ff : xs();
            {lpf, gen, cut, lv, irq} = r[9:0];
            m = mirror();
            host.wr(STATUS_SECOND_ADDR, 32'hffff_ffff);
            rdchk(STATUS_SECOND_ADDR, m);
            chk("decided", {31'h0, dec}, {31'h0, m[BIT_P1_URGENT] ^ m[BIT_P2_URGENT]});
            if (m[BIT_P1_URGENT] ^ m[BIT_P2_URGENT]) chk("next", {31'h0, p2n}, {31'h0, host.next_port2(m)});
            if (gen) chk("p1high", {31'h0, r1h}, {31'h0, lv[0] & ~(lv[1] & lpf)});
            if (gen) chk("p2high", {31'h0, r2h}, {31'h0, lv[3] & ~(lv[4] & lpf)});
        end
        // Port 1 gaps around the threshold, then a zero threshold that never drops.
        lv = 6'h00;
        irq = 1'b0;
        frame(10, 1'b0);
        frame(6, 1'b0);
        frame(5, 1'b1);
        frame(8, 1'b0);
        thr = 8'h00;
        frame(4, 1'b0);
        frame(12, 1'b0);
        results();
    end
endmodule : sssfl_status_bench

`default_nettype wire
